// ---- verilog/qb_port_cfg.svh ----
// constants of the burst-of-four sram port and its controller
// assumes a single inclusion per compile unit, guarded below
`ifndef QB_PORT_CFG_SVH
`define QB_PORT_CFG_SVH
// data and address widths of the two variants
`define QB_NARROW_DW 18
`define QB_WIDE_DW 36
`define QB_NARROW_AW 19
`define QB_WIDE_AW 18
// byte lane width and beats per access
`define QB_LANE_W 9
`define QB_BURST 4
// system clock and link clock periods in ns
`define QB_SYS_CLK_NS 20
`define QB_LINK_PERIOD_NS 160
// command fifo depth
`define QB_FIFO_DEPTH 8
`endif

// ---- verilog/qb_port_pkg.sv ----
// types used by the controller end of the burst-of-four sram port
// assumes nothing beyond a systemverilog compiler
package qb_port_pkg;
    // controller sequencing states
    typedef enum logic [1:0] {
        ctl_idle,
        ctl_write,
        ctl_read
    } ctl_state_t;
endpackage

// ---- verilog/qb_link_if.sv ----
// pin bundle between the sram device end and the controller end
// assumes both ends use the same width parameters
`timescale 1ns/10ps
interface qb_link_if #(
    parameter int DW = 18,
    parameter int AW = 19
) ();
    localparam int NL = DW / 9;
    logic k;
    logic k_n;
    logic write_port_select_n;
    logic read_port_select_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] d;
    logic [NL-1:0] byte_write_select_n;
    logic [DW-1:0] q;
    logic q_oe;
    logic output_valid_flag;
    logic echo_timing_out;
    logic echo_timing_out_n;
    wire [DW-1:0] q_bus;
    // released read bus reads as zero; q_oe tells when it is driven
    assign q_bus = q_oe ? q : '0;
    modport device (
        input k, k_n, write_port_select_n, read_port_select_n, addr, d,
        input byte_write_select_n,
        output q, q_oe, output_valid_flag, echo_timing_out,
        output echo_timing_out_n
    );
    modport ctrl (
        output k, k_n, write_port_select_n, read_port_select_n, addr, d,
        output byte_write_select_n,
        input q_bus, output_valid_flag, echo_timing_out, echo_timing_out_n
    );
endinterface

// ---- verilog/qb_fifo.sv ----
// parameterised first-in first-out buffer with valid/ready on both sides
// assumes one clock; flags are registered
`timescale 1ns/10ps
`include "qb_port_cfg.svh"
module qb_fifo #(
    parameter int W = 8,
    parameter int DEPTH = `QB_FIFO_DEPTH
) (
    input wire logic i_sys_clk, // system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_ce, // clock enable
    input wire logic i_in_valid, // write side offers a word
    output logic o_in_ready, // room for a word
    input wire logic [W-1:0] i_in_data, // word written
    output logic o_out_valid, // a word is held
    input wire logic i_out_ready, // read side takes the word
    output logic [W-1:0] o_out_data // oldest word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic [PW:0] next_count;
    logic push;
    logic pop;

    // handshakes and fill level
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;
    assign o_out_data = mem[rd_ptr];
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // storage
    always_ff @(posedge i_sys_clk) begin
        if (i_ce && push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // pointers, level and registered flags
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            o_in_ready <= 1'b0;
            o_out_valid <= 1'b0;
        end else if (i_ce) begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            o_in_ready <= (next_count != FULL);
            o_out_valid <= (next_count != '0);
        end
    end
endmodule

// ---- verilog/qb_sram_dev.sv ----
// device end: burst-of-four sram with split read and write ports
// assumes link pins arrive asynchronously and are resynchronised here
`timescale 1ns/10ps
`include "qb_port_cfg.svh"
module qb_sram_dev #(
    parameter int DW = `QB_NARROW_DW,
    parameter int AW = `QB_NARROW_AW
) (
    input wire logic i_sys_clk, // system clock, 50 MHz
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_ce, // clock enable, freezes state
    qb_link_if.device link, // pins toward the controller
    output logic o_wr_busy, // write burst in progress
    output logic o_rd_busy // read burst in progress
);
    localparam int NL = DW / `QB_LANE_W;
    localparam int LW = `QB_LANE_W;
    localparam int DEP = 2 ** AW;

    // ==================================================================
    // pin synchronisers
    // ==================================================================
    logic [1:0] k_sy;
    logic [1:0] kn_sy;
    logic [1:0] wsel_sy;
    logic [1:0] rsel_sy;
    logic [AW-1:0] addr_sy [2];
    logic [DW-1:0] d_sy [2];
    logic [NL-1:0] mask_sy [2];
    logic k_d;
    logic kn_d;

    // two flops on every pin; second stage alone feeds logic
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            k_sy <= 2'h0;
            kn_sy <= 2'h3;
            wsel_sy <= 2'h3;
            rsel_sy <= 2'h3;
            addr_sy[0] <= '0;
            addr_sy[1] <= '0;
            d_sy[0] <= '0;
            d_sy[1] <= '0;
            mask_sy[0] <= '1;
            mask_sy[1] <= '1;
            k_d <= 1'b0;
            kn_d <= 1'b1;
        end else if (i_ce) begin
            k_sy <= {k_sy[0], link.k};
            kn_sy <= {kn_sy[0], link.k_n};
            wsel_sy <= {wsel_sy[0], link.write_port_select_n};
            rsel_sy <= {rsel_sy[0], link.read_port_select_n};
            addr_sy[0] <= link.addr;
            addr_sy[1] <= addr_sy[0];
            d_sy[0] <= link.d;
            d_sy[1] <= d_sy[0];
            mask_sy[0] <= link.byte_write_select_n;
            mask_sy[1] <= mask_sy[0];
            k_d <= k_sy[1];
            kn_d <= kn_sy[1];
        end
    end

    // rising edges of both link clocks
    logic k_edge;
    logic kn_edge;
    assign k_edge = k_sy[1] & ~k_d;
    assign kn_edge = kn_sy[1] & ~kn_d;

    // ==================================================================
    // write port
    // ==================================================================
    logic wr_act;
    logic [1:0] wr_beat;
    logic [AW-1:0] wr_addr;
    logic wr_start;
    logic wr_stb;
    logic [1:0] w_beat;
    logic [AW-1:0] w_addr;

    // a write opens only on k with the port selected
    assign wr_start = k_edge & ~wsel_sy[1] & ~wr_act;
    // beats land on every k and k_n edge of an open write
    assign wr_stb = wr_start | ((k_edge | kn_edge) & wr_act);
    // address taken from pins only at the opening k edge
    assign w_addr = wr_start ? addr_sy[1] : wr_addr;
    assign w_beat = wr_start ? 2'h0 : wr_beat;

    // write burst sequencing, a deselected port opens no burst but an open one runs on
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_act <= 1'b0;
            wr_beat <= 2'h0;
            wr_addr <= '0;
        end else if (i_ce) begin
            if (wr_start) begin
                wr_act <= 1'b1;
                wr_beat <= 2'h1;
                wr_addr <= addr_sy[1];
            end else if (wr_stb) begin
                wr_beat <= wr_beat + 2'h1;
                wr_act <= (wr_beat != 2'h3);
            end
        end
    end

    // ==================================================================
    // storage: four arrays, one per beat, split into byte lanes
    // ==================================================================
    logic rd_pend;
    logic [2:0] rd_left;
    logic [1:0] rd_beat;
    logic [AW-1:0] rd_addr;
    logic [1:0] r_beat;
    logic [DW-1:0] rd_word;

    assign r_beat = rd_pend ? 2'h0 : rd_beat;

    // one memory per lane; a high byte select leaves the byte alone
    for (genvar g = 0; g < NL; g++) begin : g_lane
        logic [LW-1:0] lane_mem [`QB_BURST][DEP];
        always_ff @(posedge i_sys_clk) begin
            if (i_ce && wr_stb && !mask_sy[1][g]) begin
                lane_mem[w_beat][w_addr] <= d_sy[1][g*LW +: LW];
            end
        end
        assign rd_word[g*LW +: LW] = lane_mem[r_beat][rd_addr];
    end

    // ==================================================================
    // read port
    // ==================================================================
    logic rd_start;

    // a new read may be taken on the k edge of the last beat
    assign rd_start = k_edge & ~rsel_sy[1] & (rd_left <= 3'h1);

    // read address and pending flag, taken only on k
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_pend <= 1'b0;
            rd_addr <= '0;
        end else if (i_ce) begin
            if (rd_start) begin
                rd_pend <= 1'b1;
                rd_addr <= addr_sy[1];
            end else if (kn_edge && rd_pend) begin
                rd_pend <= 1'b0;
            end
        end
    end

    // beat launch: first on k_n, then alternating, four in all
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_left <= 3'h0;
            rd_beat <= 2'h0;
            link.q <= '0;
            link.q_oe <= 1'b0;
            link.output_valid_flag <= 1'b0;
        end else if (i_ce) begin
            if (kn_edge && rd_pend) begin
                rd_left <= 3'h3;
                rd_beat <= 2'h1;
                link.q <= rd_word;
                link.q_oe <= 1'b1;
                link.output_valid_flag <= 1'b1;
            end else if ((k_edge || kn_edge) && rd_left != 3'h0) begin
                rd_left <= rd_left - 3'h1;
                rd_beat <= rd_beat + 2'h1;
                link.q <= rd_word;
            end else if (kn_edge) begin
                link.q_oe <= 1'b0;
                link.output_valid_flag <= 1'b0;
            end
        end
    end

    // ==================================================================
    // echo clocks and status
    // ==================================================================
    // echo follows k with the same delay as the data launch
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link.echo_timing_out <= 1'b0;
            link.echo_timing_out_n <= 1'b1;
            o_wr_busy <= 1'b0;
            o_rd_busy <= 1'b0;
        end else if (i_ce) begin
            link.echo_timing_out <= k_sy[1];
            link.echo_timing_out_n <= ~k_sy[1];
            o_wr_busy <= wr_act | wr_start;
            o_rd_busy <= rd_pend | (rd_left != 3'h0) | rd_start;
        end
    end
endmodule

// ---- verilog/qb_sram_ctl.sv ----
// controller end: makes the link clocks and runs queued bursts
// assumes one command per two link clock periods, reads and writes mixed
`timescale 1ns/10ps
`include "qb_port_cfg.svh"
module qb_sram_ctl #(
    parameter int DW = `QB_NARROW_DW,
    parameter int AW = `QB_NARROW_AW
) (
    input wire logic i_sys_clk, // system clock, 50 MHz
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_ce, // clock enable, freezes state
    qb_link_if.ctrl link, // pins toward the device
    input wire logic i_req_valid, // command offered
    output logic o_req_ready, // command queue has room
    input wire logic i_req_write, // 1 write, 0 read
    input wire logic [AW-1:0] i_req_addr, // burst address
    input wire logic [4*DW-1:0] i_req_data, // write beats, beat 0 low
    input wire logic [4*(DW/9)-1:0] i_req_bws_n, // lane masks per beat
    output logic o_rd_valid, // read beat pulse
    output logic [1:0] o_rd_beat, // beat number of o_rd_data
    output logic [DW-1:0] o_rd_data // read beat
);
    localparam int NL = DW / `QB_LANE_W;
    localparam int FW = 1 + AW + 4 * NL + 4 * DW;
    localparam int PER = `QB_LINK_PERIOD_NS / `QB_SYS_CLK_NS;
    localparam int HALF = PER / 2;
    localparam logic [7:0] PH_LAST = 8'(PER - 1);
    localparam logic [7:0] PH_FALL = 8'(HALF - 1);
    localparam logic [7:0] PH_LK = 8'(PER - 3);
    localparam logic [7:0] PH_LKN = 8'(HALF - 3);

    // ==================================================================
    // command queue
    // ==================================================================
    logic f_valid;
    logic f_pop;
    logic [FW-1:0] f_data;
    qb_fifo #(.W(FW), .DEPTH(`QB_FIFO_DEPTH)) u_cmdq (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_in_valid(i_req_valid),
        .o_in_ready(o_req_ready),
        .i_in_data({i_req_write, i_req_addr, i_req_bws_n, i_req_data}),
        .o_out_valid(f_valid),
        .i_out_ready(f_pop),
        .o_out_data(f_data)
    );

    // ==================================================================
    // link clock divider
    // ==================================================================
    logic [7:0] ph;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph <= 8'h00;
            link.k <= 1'b0;
            link.k_n <= 1'b1;
        end else if (i_ce) begin
            ph <= (ph == PH_LAST) ? 8'h00 : ph + 8'h01;
            if (ph == PH_LAST) begin
                link.k <= 1'b1;
                link.k_n <= 1'b0;
            end else if (ph == PH_FALL) begin
                link.k <= 1'b0;
                link.k_n <= 1'b1;
            end
        end
    end

    // pins change two system clocks ahead of each link edge
    logic launch_k;
    logic launch_kn;
    assign launch_k = (ph == PH_LK);
    assign launch_kn = (ph == PH_LKN);

    // ==================================================================
    // burst sequencer
    // ==================================================================
    qb_port_pkg::ctl_state_t state;
    logic [1:0] cb;
    logic [4*DW-1:0] w_data;
    logic [4*NL-1:0] w_bws;

    assign f_pop = launch_k & (cb == 2'h0) & f_valid;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= qb_port_pkg::ctl_idle;
            cb <= 2'h0;
            w_data <= '0;
            w_bws <= '1;
            link.write_port_select_n <= 1'b1;
            link.read_port_select_n <= 1'b1;
            link.addr <= '0;
            link.d <= '0;
            link.byte_write_select_n <= '1;
        end else if (i_ce) begin
            if (f_pop) begin
                cb <= 2'h1;
                link.addr <= f_data[FW-2 -: AW];
                w_data <= f_data[4*DW-1:0];
                w_bws <= f_data[4*DW +: 4*NL];
                if (f_data[FW-1]) begin
                    state <= qb_port_pkg::ctl_write;
                    link.write_port_select_n <= 1'b0;
                    link.d <= f_data[DW-1:0];
                    link.byte_write_select_n <= f_data[4*DW +: NL];
                end else begin
                    state <= qb_port_pkg::ctl_read;
                    link.read_port_select_n <= 1'b0;
                    link.byte_write_select_n <= '1;
                end
            end else if ((launch_k || launch_kn) && cb != 2'h0) begin
                cb <= cb + 2'h1;
                link.write_port_select_n <= 1'b1;
                link.read_port_select_n <= 1'b1;
                case (state)
                    qb_port_pkg::ctl_write: begin
                        link.d <= w_data[cb*DW +: DW];
                        link.byte_write_select_n <= w_bws[cb*NL +: NL];
                    end
                    default: begin
                        link.byte_write_select_n <= '1;
                    end
                endcase
            end else if (launch_k) begin
                state <= qb_port_pkg::ctl_idle;
                link.write_port_select_n <= 1'b1;
                link.read_port_select_n <= 1'b1;
                link.byte_write_select_n <= '1;
            end
        end
    end

    // ==================================================================
    // read capture on echo edges
    // ==================================================================
    logic [1:0] echo_sy;
    logic [1:0] vld_sy;
    logic [DW-1:0] q_sy [2];
    logic echo_d;
    logic [1:0] rx_cnt;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            echo_sy <= 2'h0;
            vld_sy <= 2'h0;
            q_sy[0] <= '0;
            q_sy[1] <= '0;
            echo_d <= 1'b0;
            rx_cnt <= 2'h0;
            o_rd_valid <= 1'b0;
            o_rd_beat <= 2'h0;
            o_rd_data <= '0;
        end else if (i_ce) begin
            echo_sy <= {echo_sy[0], link.echo_timing_out};
            vld_sy <= {vld_sy[0], link.output_valid_flag};
            q_sy[0] <= link.q_bus;
            q_sy[1] <= q_sy[0];
            echo_d <= echo_sy[1];
            o_rd_valid <= (echo_sy[1] ^ echo_d) & vld_sy[1];
            if ((echo_sy[1] ^ echo_d) && vld_sy[1]) begin
                // bursts are always four beats, so a free count stays aligned
                o_rd_data <= q_sy[1];
                o_rd_beat <= rx_cnt;
                rx_cnt <= rx_cnt + 2'h1;
            end
        end
    end
endmodule

// ---- tb/qb_port_checker.sv ----
// concurrent checks on the link between the sram end and its controller
// assumes the link signals arrive as plain inputs sampled by i_sys_clk
`timescale 1ns/10ps
module qb_port_checker #(
    parameter int DW = 18,
    parameter int AW = 19
) (
    input wire logic i_sys_clk, // system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic k, // link clock
    input wire logic k_n, // complement of k
    input wire logic wr_sel_n, // write select, active low
    input wire logic rd_sel_n, // read select, active low
    input wire logic [AW-1:0] addr, // burst address
    input wire logic [DW-1:0] q, // read beat
    input wire logic q_oe, // device drives q
    input wire logic out_valid, // read data valid
    input wire logic echo, // echo clock
    input wire logic echo_n // echo clock complement
);
    default clocking dc @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    // ==========================================================
    // helper logic
    // counts cycles with the valid flag high, cleared when it drops
    logic [7:0] vld_cnt;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vld_cnt <= 8'h00;
        end else begin
            vld_cnt <= out_valid ? vld_cnt + 8'h01 : 8'h00;
        end
    end
    // ==========================================================
    // properties
    k_pair_a: assert property (k_n != k)
        else $error("k_n is not the complement of k");
    k_half_a: assert property ($changed(k) |=>
        $stable(k)[*3] ##1 $changed(k))
        else $error("link clock half period is not four cycles");
    echo_pair_a: assert property (echo_n != echo)
        else $error("echo complement does not oppose the echo clock");
    echo_run_a: assert property ($changed(echo) |=>
        $stable(echo)[*3] ##1 $changed(echo))
        else $error("echo clock does not toggle every four cycles");
    vld_edge_a: assert property ($changed(out_valid) |->
        $changed(echo))
        else $error("valid flag moved off an echo clock edge");
    vld_drive_a: assert property (out_valid == q_oe)
        else $error("output enable and valid flag disagree");
    beat_edge_a: assert property (out_valid && $changed(q) |->
        $changed(echo))
        else $error("read beat changed off an echo clock edge");
    burst_four_a: assert property ($fell(out_valid) |->
        vld_cnt[3:0] == 4'h0 && vld_cnt != 8'h00)
        else $error("read burst is not a whole number of four beats");
    wr_select_a: assert property ($fell(wr_sel_n) |->
        ##[1:4] (k && !wr_sel_n))
        else $error("write select not held low into a k rise");
    rd_select_a: assert property ($fell(rd_sel_n) |->
        ##[1:4] (k && !rd_sel_n))
        else $error("read select not held low into a k rise");
    addr_hold_a: assert property (!wr_sel_n && !$past(wr_sel_n) |->
        $stable(addr))
        else $error("address moved while write select low");
    rd_answer_a: assert property ($rose(k) && !rd_sel_n &&
        !out_valid |-> ##[4:12] $rose(out_valid))
        else $error("read data did not start after a read select");
endmodule

// ---- tb/quad_rate_burst4_sram_port_test.sv ----
// self-checking bench: controller and sram end joined through the link
// assumes a 50 MHz system clock and a small address width for the array
`timescale 1ns/10ps
module quad_rate_burst4_sram_port_test;
    localparam int DW = 18;
    localparam int AW = 6;
    localparam int NL = DW / 9;
    // ==========================================================
    // bench plumbing
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [AW-1:0] req_addr = 6'h00;
    logic [4*DW-1:0] req_data = 72'h0;
    logic [4*NL-1:0] req_bws_n = 8'hFF;
    logic req_ready;
    logic rd_valid;
    logic [1:0] rd_beat;
    logic [DW-1:0] rd_data;
    logic saw_full = 1'b0;
    logic wr_busy;
    logic rd_busy;
    logic [1:0] saw_busy = 2'h0;
    logic [DW-1:0] mem [0:63][0:3];
    logic [31:0] rx [$];
    logic [31:0] ex [$];
    int errors = 0;
    int checked = 0;
    qb_link_if #(.DW(DW), .AW(AW)) i_qb_link_if ();
    qb_sram_dev #(.DW(DW), .AW(AW)) i_qb_sram_dev (.i_sys_clk(sys_clk),
        .i_rst_n(rst_n), .i_ce(1'b1), .link(i_qb_link_if.device),
        .o_wr_busy(wr_busy), .o_rd_busy(rd_busy));
    qb_sram_ctl #(.DW(DW), .AW(AW)) i_qb_sram_ctl (.i_sys_clk(sys_clk),
        .i_rst_n(rst_n), .i_ce(1'b1), .link(i_qb_link_if.ctrl),
        .i_req_valid(req_valid), .o_req_ready(req_ready),
        .i_req_write(req_write), .i_req_addr(req_addr),
        .i_req_data(req_data), .i_req_bws_n(req_bws_n),
        .o_rd_valid(rd_valid), .o_rd_beat(rd_beat), .o_rd_data(rd_data));
    qb_port_checker #(.DW(DW), .AW(AW)) i_qb_port_checker (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .k(i_qb_link_if.k),
        .k_n(i_qb_link_if.k_n),
        .wr_sel_n(i_qb_link_if.write_port_select_n),
        .rd_sel_n(i_qb_link_if.read_port_select_n),
        .addr(i_qb_link_if.addr),
        .q(i_qb_link_if.q), .q_oe(i_qb_link_if.q_oe),
        .out_valid(i_qb_link_if.output_valid_flag),
        .echo(i_qb_link_if.echo_timing_out),
        .echo_n(i_qb_link_if.echo_timing_out_n));
    // system clock, 20 ns period
    always #10 sys_clk = ~sys_clk;
    // collects read beats where the one-cycle pulse has settled
    always @(negedge sys_clk) begin
        saw_busy = saw_busy | {wr_busy, rd_busy}; // busy flags ever seen
        if (rd_valid === 1'b1) begin
            rx.push_back({12'h000, rd_beat, rd_data});
        end
    end
    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // offers one command and holds it until the edge that takes it
    task automatic send(input logic w, input logic [AW-1:0] a,
                        input logic [4*DW-1:0] dt, input logic [4*NL-1:0] m);
        int n;
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_data = dt;
        req_bws_n = m;
        n = 0;
        while (req_ready !== 1'b1 && n < 400) begin
            saw_full = 1'b1;
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 400) errors++;
        @(posedge sys_clk);
        #1;
        // reference array follows each write, reads snapshot it in order
        if (w) begin
            for (int b = 0; b < 4; b++)
                for (int g = 0; g < NL; g++)
                    if (!m[b*NL+g]) mem[a][b][g*9 +: 9] = dt[b*DW+g*9 +: 9];
        end else begin
            for (int b = 0; b < 4; b++)
                ex.push_back({12'h000, 2'(b), mem[a][b]});
        end
    endtask
    // waits for every expected beat, compares, then checks bus release
    task automatic drain();
        int n;
        req_valid = 1'b0;
        n = 0;
        while (rx.size() < ex.size() && n < 3000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(32'(rx.size()), 32'(ex.size()));
        while (ex.size() > 0 && rx.size() > 0)
            chk(rx.pop_front(), ex.pop_front());
        ex.delete();
        rx.delete();
        repeat (40) @(posedge sys_clk);
        #1;
        chk({31'h0, i_qb_link_if.q_oe}, 32'h0);
        chk({14'h0000, i_qb_link_if.q_bus}, 32'h0);
        chk({30'h0, wr_busy, rd_busy}, 32'h0);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========================================================
    // tests
    // full write then two back-to-back reads of the same word
    task automatic t_basic();
        send(1'b1, 6'h05, 72'hA5A5123456789ABCDE, 8'h00);
        send(1'b0, 6'h05, 72'h0, 8'h00);
        send(1'b0, 6'h05, 72'h0, 8'h00);
        drain();
        chk({30'h0, saw_busy}, 32'h3);
        $display("test basic done");
    endtask
    // masked write: beat0 whole, beat1 lane1, beat2 lane0, beat3 none
    task automatic t_mask();
        send(1'b1, 6'h05, 72'h2468ACE13579BDF024, 8'hE4);
        send(1'b0, 6'h05, 72'h0, 8'h00);
        drain();
        $display("test mask done");
    endtask
    // command queue filled past its depth, writes then reads of them
    task automatic t_fill();
        saw_full = 1'b0;
        for (int i = 0; i < 12; i++) begin
            if (i < 6)
                send(1'b1, 6'(16 + i), {18'(i + 18'h300), 18'(i + 18'h200),
                    18'(i + 18'h100), 18'(i)}, 8'h00);
            else
                send(1'b0, 6'(10 + i), 72'h0, 8'h00);
        end
        chk({31'h0, saw_full}, 32'h1);
        drain();
        $display("test fill done");
    endtask
    // ==========================================================
    // sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        t_basic();
        t_mask();
        t_fill();
        close_out();
    end
    // watchdog: the tests need well under 2000 cycles
    initial begin
        #(20 * 6000);
        errors++;
        close_out();
    end
endmodule
